// ==== hw/acu_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "acu_defines.svh"

module acu_top
    import acu_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter core side.
    input wire logic trigger_event,
    input wire logic result_valid,
    input wire logic [RES_W-1:0] sample_first,
    input wire logic [RES_W-1:0] sample_second,
    input wire logic threshold_met,
    output logic conversion_retrigger,
    output logic threshold_test_due,
    output logic irq
);

    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------
    acu_mode_t compute_mode_select;
    logic double_sample_enable;
    logic [2:0] shift_amount;
    logic accumulator_clear_request;
    logic [7:0] repeat_target;
    logic [7:0] sample_count;
    logic [15:0] accumulator_value;
    logic [15:0] filter_output_register;
    logic conversion_done_flag;
    logic threshold_flag;
    logic accumulator_overflow_flag;
    logic [`ACU_ST_W-1:0] irq_mask;
    acu_burst_t burst_state;

    logic [15:0] next_acc;
    logic sum_overflow;
    logic [7:0] next_count;
    logic wr_en;
    logic rd_en;
    logic addr_hit;
    logic trig_clears;
    logic test_now;
    logic [15:0] acc_base;
    logic [7:0] cnt_base;
    logic [`ACU_ST_W-1:0] status_vec;
    logic [`ACU_ST_W-1:0] w1c;

    // Saturating increment of the sample counter.
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        if (v == `ACU_CNT_MAX) begin
            sat_inc = v;
        end else begin
            sat_inc = v + 8'h01;
        end
    endfunction : sat_inc

    // Address decode shared by reads and writes.
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `ACU_OFS_CTRL, `ACU_OFS_RPT, `ACU_OFS_CNT, `ACU_OFS_ACC,
            `ACU_OFS_FLT, `ACU_OFS_STAT, `ACU_OFS_MASK: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // ------------------------------------------------------------------
    // APB handshake.
    // ------------------------------------------------------------------

    // Every access completes in its first access cycle.
    assign pready = psel & penable;
    assign addr_hit = is_mapped(paddr);
    assign pslverr = psel & penable & ~addr_hit;
    assign wr_en = psel & penable & pwrite & addr_hit;
    assign rd_en = psel & ~penable & ~pwrite;
    assign w1c = wr_en && (paddr == `ACU_OFS_STAT) ? pwdata[`ACU_ST_W-1:0] : '0;
    assign status_vec = {accumulator_overflow_flag, threshold_flag, conversion_done_flag};

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                `ACU_OFS_CTRL: prdata <= {24'h0, accumulator_clear_request, shift_amount,
                                          double_sample_enable, compute_mode_select};
                `ACU_OFS_RPT: prdata <= {24'h0, repeat_target};
                `ACU_OFS_CNT: prdata <= {24'h0, sample_count};
                `ACU_OFS_ACC: prdata <= {16'h0, accumulator_value};
                `ACU_OFS_FLT: prdata <= {16'h0, filter_output_register};
                `ACU_OFS_STAT: prdata <= {29'h0, status_vec};
                `ACU_OFS_MASK: prdata <= {29'h0, irq_mask};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------------

    // Mode, double-sample, shift and repeat target written by software.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            compute_mode_select <= ACU_MD_BASIC;
            double_sample_enable <= 1'b0;
            shift_amount <= 3'h0;
            repeat_target <= `ACU_RST_RPT;
            irq_mask <= '0;
        end else if (wr_en) begin
            if (paddr == `ACU_OFS_CTRL) begin
                compute_mode_select <= acu_mode_t'(pwdata[`ACU_CTRL_MODE_MSB:`ACU_CTRL_MODE_LSB]);
                double_sample_enable <= pwdata[`ACU_CTRL_DSEN];
                shift_amount <= pwdata[`ACU_CTRL_SHIFT_MSB:`ACU_CTRL_SHIFT_LSB];
            end
            if (paddr == `ACU_OFS_RPT) begin
                repeat_target <= pwdata[7:0];
            end
            if (paddr == `ACU_OFS_MASK) begin
                irq_mask <= pwdata[`ACU_ST_W-1:0];
            end
        end
    end

    // Clear request is set by software and dropped once clearing is done.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            accumulator_clear_request <= 1'b0;
        end else if (accumulator_clear_request) begin
            accumulator_clear_request <= 1'b0;
        end else if (wr_en && paddr == `ACU_OFS_CTRL) begin
            accumulator_clear_request <= pwdata[`ACU_CTRL_CLR];
        end
    end

    // ------------------------------------------------------------------
    // Computation datapath.
    // ------------------------------------------------------------------

    // A trigger starts a fresh set in burst mode, and in average mode once a test has been done.
    always_comb begin
        case (compute_mode_select)
            ACU_MD_AVG: trig_clears = trigger_event && (sample_count >= repeat_target);
            ACU_MD_BURST: trig_clears = trigger_event;
            default: trig_clears = 1'b0;
        endcase
    end

    // A result arriving with its trigger sees the already cleared set.
    assign acc_base = trig_clears ? 16'h0000 : accumulator_value;
    assign cnt_base = trig_clears ? 8'h00 : sample_count;
    assign next_count = sat_inc(cnt_base);

    acu_accum_alu #(
        .RES_W(RES_W)
    ) u_alu (
        .mode(compute_mode_select),
        .double_sample_enable(double_sample_enable),
        .shift_amount(shift_amount),
        .sample_first(sample_first),
        .sample_second(sample_second),
        .acc_in(acc_base),
        .acc_out(next_acc),
        .overflow(sum_overflow)
    );

    // Decides whether the result just processed is due for a threshold test.
    always_comb begin
        test_now = 1'b0;
        if (result_valid) begin
            case (compute_mode_select)
                ACU_MD_BASIC: test_now = 1'b1;
                ACU_MD_ACCUM: test_now = 1'b1;
                ACU_MD_AVG: test_now = (next_count >= repeat_target);
                ACU_MD_BURST: test_now = (next_count >= repeat_target);
                ACU_MD_LPF: test_now = (next_count >= repeat_target);
                default: test_now = 1'b0;
            endcase
        end
    end

    // Accumulator and counter; a software clear takes priority over a sample.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            accumulator_value <= 16'h0000;
            sample_count <= 8'h00;
        end else if (accumulator_clear_request) begin
            accumulator_value <= 16'h0000;
            sample_count <= 8'h00;
        end else if (result_valid && compute_mode_select != ACU_MD_BASIC) begin
            accumulator_value <= next_acc;
            sample_count <= next_count;
        end else if (trig_clears) begin
            accumulator_value <= 16'h0000;
            sample_count <= 8'h00;
        end
    end

    // Scaled copy of the accumulator after each sample outside basic mode.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            filter_output_register <= 16'h0000;
        end else if (result_valid && compute_mode_select != ACU_MD_BASIC) begin
            filter_output_register <= next_acc >> shift_amount;
        end
    end

    // Burst sequencer asks the core for another conversion until the target.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            burst_state <= ACU_BST_IDLE;
            conversion_retrigger <= 1'b0;
        end else begin
            conversion_retrigger <= 1'b0;
            case (burst_state)
                ACU_BST_IDLE: begin
                    if (compute_mode_select == ACU_MD_BURST && trigger_event) begin
                        burst_state <= ACU_BST_RUN;
                    end
                end
                ACU_BST_RUN: begin
                    if (compute_mode_select != ACU_MD_BURST || accumulator_clear_request) begin
                        burst_state <= ACU_BST_IDLE;
                    end else if (result_valid) begin
                        if (next_count < repeat_target) begin
                            conversion_retrigger <= 1'b1;
                        end else begin
                            burst_state <= ACU_BST_IDLE;
                        end
                    end
                end
                default: burst_state <= ACU_BST_IDLE;
            endcase
        end
    end

    // Test strobe to the threshold comparator, one cycle per due test.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            threshold_test_due <= 1'b0;
        end else begin
            threshold_test_due <= test_now;
        end
    end

    // ------------------------------------------------------------------
    // Sticky flags and interrupt.
    // ------------------------------------------------------------------

    // Done flag; a new conversion wins over a write-one clear.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            conversion_done_flag <= 1'b0;
        end else if (result_valid) begin
            conversion_done_flag <= 1'b1;
        end else if (w1c[`ACU_ST_DONE]) begin
            conversion_done_flag <= 1'b0;
        end
    end

    // Threshold flag is set by the comparator outcome, or by a set overflow flag, one cycle after the test strobe.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            threshold_flag <= 1'b0;
        end else if (threshold_test_due && (threshold_met || accumulator_overflow_flag)) begin
            threshold_flag <= 1'b1;
        end else if (w1c[`ACU_ST_THR]) begin
            threshold_flag <= 1'b0;
        end
    end

    // Overflow flag; cleared by the clear request or a write-one clear.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            accumulator_overflow_flag <= 1'b0;
        end else if (accumulator_clear_request) begin
            accumulator_overflow_flag <= 1'b0;
        end else if (result_valid && compute_mode_select != ACU_MD_BASIC && sum_overflow) begin
            accumulator_overflow_flag <= 1'b1;
        end else if (w1c[`ACU_ST_OVF]) begin
            accumulator_overflow_flag <= 1'b0;
        end
    end

    // Level interrupt while any unmasked flag is set.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_vec & irq_mask);
        end
    end

endmodule : acu_top

`default_nettype wire

// ==== hw/acu_defines.svh ====
`ifndef ACU_DEFINES_SVH
`define ACU_DEFINES_SVH

// Register byte offsets.
`define ACU_OFS_CTRL 8'h00
`define ACU_OFS_RPT 8'h04
`define ACU_OFS_CNT 8'h08
`define ACU_OFS_ACC 8'h0c
`define ACU_OFS_FLT 8'h10
`define ACU_OFS_STAT 8'h14
`define ACU_OFS_MASK 8'h18

// Control register fields.
`define ACU_CTRL_MODE_LSB 0
`define ACU_CTRL_MODE_MSB 2
`define ACU_CTRL_DSEN 3
`define ACU_CTRL_SHIFT_LSB 4
`define ACU_CTRL_SHIFT_MSB 6
`define ACU_CTRL_CLR 7

// Status and mask register fields.
`define ACU_ST_DONE 0
`define ACU_ST_THR 1
`define ACU_ST_OVF 2
`define ACU_ST_W 3

// Reset value, counter maximum and accumulator limit.
`define ACU_RST_RPT 8'h00
`define ACU_CNT_MAX 8'hff
`define ACU_ACC_MAX 18'h0ffff

`endif

// ==== hw/acu_pkg.sv ====
package acu_pkg;

    // Post-conversion processing modes.
    typedef enum logic [2:0] {
        ACU_MD_BASIC = 3'b000,
        ACU_MD_ACCUM = 3'b001,
        ACU_MD_AVG = 3'b010,
        ACU_MD_BURST = 3'b011,
        ACU_MD_LPF = 3'b100
    } acu_mode_t;

    // Burst sequencer states.
    typedef enum logic [0:0] {
        ACU_BST_IDLE = 1'b0,
        ACU_BST_RUN = 1'b1
    } acu_burst_t;

endpackage : acu_pkg

// ==== hw/acu_accum_alu.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "acu_defines.svh"

// ----------------------------------------------------------------------
// Accumulator arithmetic for one processed sample.
// ----------------------------------------------------------------------
module acu_accum_alu
    import acu_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire acu_mode_t mode,
    input wire logic double_sample_enable,
    input wire logic [2:0] shift_amount,
    input wire logic [RES_W-1:0] sample_first,
    input wire logic [RES_W-1:0] sample_second,
    input wire logic [15:0] acc_in,
    output logic [15:0] acc_out,
    output logic overflow
);

    logic signed [17:0] addend;
    logic signed [17:0] acc_ext;
    logic signed [17:0] decay;
    logic signed [17:0] sum;

    // Chooses the single sample or the second-minus-first difference.
    always_comb begin
        if (double_sample_enable) begin
            addend = $signed({1'b0, 17'(sample_second)}) - $signed({1'b0, 17'(sample_first)});
        end else begin
            addend = $signed({1'b0, 17'(sample_first)});
        end
    end

    // Plain accumulation, or a first-order recursive filter in low-pass mode.
    always_comb begin
        acc_ext = $signed({2'b00, acc_in});
        decay = $signed({2'b00, acc_in >> shift_amount});
        if (mode == ACU_MD_LPF) begin
            sum = acc_ext + addend - decay;
        end else begin
            sum = acc_ext + addend;
        end
        acc_out = sum[15:0];
        overflow = (sum > $signed(`ACU_ACC_MAX));
    end

endmodule : acu_accum_alu

`default_nettype wire

// ==== sim/acu_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the result computation unit.
// ----------------------------------------------------------------------
module acu_sva
    import acu_pkg::*;
#(
    parameter int RES_W = 10
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic trigger_event,
    input wire logic result_valid,
    input wire logic [RES_W-1:0] sample_first,
    input wire logic [RES_W-1:0] sample_second,
    input wire logic threshold_met,
    input wire logic conversion_retrigger,
    input wire logic threshold_test_due,
    input wire logic irq
);
    logic [2:0] mode_q;
    // Shadow of the mode field, taken from completed control writes.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q <= 3'h0;
        end else if (psel && penable && pwrite && paddr == 8'h00) begin
            mode_q <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);
    property p_rt_src;
        conversion_retrigger |-> $past(result_valid);
    endproperty
    a_rt_src: assert property (p_rt_src) else $error("retrigger without a result");
    property p_rt_mode;
        conversion_retrigger |-> mode_q == ACU_MD_BURST;
    endproperty
    a_rt_mode: assert property (p_rt_mode) else $error("retrigger outside burst mode");
    property p_rt_test;
        conversion_retrigger |-> !threshold_test_due;
    endproperty
    a_rt_test: assert property (p_rt_test) else $error("retrigger and test together");
    property p_burst;
        result_valid && mode_q == ACU_MD_BURST |=> conversion_retrigger || threshold_test_due;
    endproperty
    a_burst: assert property (p_burst) else $error("burst result left no follow-up");
    property p_every;
        result_valid && (mode_q == ACU_MD_BASIC || mode_q == ACU_MD_ACCUM) |=> threshold_test_due;
    endproperty
    a_every: assert property (p_every) else $error("sample not tested");
    property p_due_src;
        threshold_test_due |-> $past(result_valid);
    endproperty
    a_due_src: assert property (p_due_src) else $error("test without a result");
    property p_ready;
        psel && penable |-> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access phase not answered");
    property p_err;
        psel && penable && !pwrite && paddr > 8'h18 |-> pslverr && prdata == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("unmapped read not refused");
    property p_ok;
        psel && penable && paddr < 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
endmodule : acu_sva

bind acu_top acu_sva #(.RES_W(RES_W)) u_sva (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_event(trigger_event), .result_valid(result_valid), .sample_first(sample_first),
    .sample_second(sample_second), .threshold_met(threshold_met), .conversion_retrigger(conversion_retrigger),
    .threshold_test_due(threshold_test_due), .irq(irq));
`default_nettype wire

// ==== sim/acu_core_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Converter core: one conversion per start, lat cycles long.
// ----------------------------------------------------------------------
module acu_core_model #(
    parameter int RES_W = 10
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [3:0] lat,
    output logic result_valid,
    output logic [RES_W-1:0] s1,
    output logic [RES_W-1:0] s2
);
    int left;
    // A start while busy is dropped; stale sample lines flip every cycle.
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 0;
            result_valid <= 1'b0;
            s1 <= '0;
            s2 <= '0;
        end else begin
            result_valid <= left == 1;
            s1 <= (left == 1) ? RES_W'($urandom) : ~s1;
            s2 <= (left == 1) ? RES_W'($urandom) : ~s2;
            if (left > 0) begin
                left <= left - 1;
            end else if (start) begin
                left <= int'(lat);
            end
        end
    end
endmodule : acu_core_model
`default_nettype wire

// ==== sim/tb_adc_result_computation_unit.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench for the result computation unit.
// ----------------------------------------------------------------------
module tb_adc_result_computation_unit;
    import acu_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trigger_event = 1'b0;
    logic threshold_met = 1'b0, pready, pslverr, result_valid, conversion_retrigger, threshold_test_due, irq, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0] s1, s2;
    logic [3:0] lat = 4'h1;
    int n_errors = 0, tests_run = 0, cyc = 0, k;
    int mode = 0, dsen = 0, sh = 0, rpt = 0, acc = 0, cnt = 0, st = 0, msk = 0, flt = 0, sum;
    logic e_rt = 1'b0, e_due = 1'b0;

    acu_top #(.RES_W(10)) dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_event(trigger_event), .result_valid(result_valid), .sample_first(s1), .sample_second(s2),
        .threshold_met(threshold_met), .conversion_retrigger(conversion_retrigger),
        .threshold_test_due(threshold_test_due), .irq(irq));
    acu_core_model #(.RES_W(10)) core (.ref_clk(ref_clk), .rst_b(rst_b), .start(trigger_event || conversion_retrigger),
        .lat(lat), .result_valid(result_valid), .s1(s1), .s2(s2));

    // Free-running 200 MHz clock.
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // One APB transfer; read data and error are taken at the ready edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Reference model, advanced at every edge and compared with each pulse.
    always @(posedge ref_clk) begin
        if (rst_b) begin
            check(conversion_retrigger, e_rt);
            check(threshold_test_due, e_due);
            if (psel && penable && pwrite && paddr == 8'h00) begin
                mode = pwdata[2:0];
                dsen = pwdata[3];
                sh = pwdata[6:4];
                if (pwdata[7]) begin
                    acc = 0;
                    cnt = 0;
                    st = st & 3;
                end
            end
            if (psel && penable && pwrite && paddr == 8'h04) rpt = pwdata[7:0];
            if (psel && penable && pwrite && paddr == 8'h14) st = st & ~pwdata[2:0];
            if (psel && penable && pwrite && paddr == 8'h18) msk = pwdata[2:0];
            if (e_due && (threshold_met || st[2])) st = st | 2;
            e_rt = 1'b0;
            e_due = 1'b0;
            if (trigger_event && ((mode == 2 && cnt >= rpt) || mode == 3)) begin
                acc = 0;
                cnt = 0;
            end
            if (result_valid) begin
                sum = dsen ? int'(s2) - int'(s1) : int'(s1);
                st = st | 1;
                if (mode != 0) begin
                    sum = (mode == 4) ? sum + acc - (acc >> sh) : sum + acc;
                    if (sum > 65535) st = st | 4;
                    acc = sum & 65535;
                    cnt = (cnt == 255) ? 255 : cnt + 1;
                    flt = acc >> sh;
                end
                e_due = mode < 2 || cnt >= rpt;
                e_rt = mode == 3 && cnt < rpt;
            end
        end
    end

    // One scenario: set up mode md with random settings, run n triggers, check registers and interrupt.
    task automatic run(input int md, input int n);
        int i, j, idle;
        lat <= 4'($urandom_range(6, 1));
        threshold_met <= 1'($urandom_range(1, 0));
        apb(1'b1, 8'h04, $urandom_range(4, 1));
        apb(1'b1, 8'h18, $urandom_range(7, 0));
        apb(1'b1, 8'h00, {24'h0, 1'b1, 3'($urandom_range(7, 0)), 1'($urandom_range(1, 0)), 3'(md)});
        apb(1'b1, 8'h14, 32'h7);
        for (i = 0; i < n; i++) begin
            trigger_event <= 1'b1;
            @(posedge ref_clk);
            trigger_event <= 1'b0;
            idle = 0;
            for (j = 0; j < 500 && idle < 12; j++) begin
                @(posedge ref_clk);
                idle = (result_valid || conversion_retrigger) ? 0 : idle + 1;
            end
        end
        apb(1'b0, 8'h08, 32'h0);
        check(rd, cnt);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, rpt);
        apb(1'b0, 8'h0c, 32'h0);
        check(rd, acc);
        apb(1'b0, 8'h10, 32'h0);
        check(rd, flt);
        apb(1'b0, 8'h14, 32'h0);
        check(rd, st);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, mode + dsen * 8 + sh * 16);
        check(irq, (st & msk) != 0);
        apb(1'b1, 8'h14, 32'h7);
        apb(1'b0, 8'h1c, 32'h0);
        check(32'(err), 32'h1);
        check(rd, 32'h0);
        check(irq, 1'b0);
        $display("test of mode %0d with %0d triggers done", md, n);
    endtask : run

    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // Main sequence: reset values, every mode, then counter saturation with overflow.
    initial begin
        void'($urandom(10878));
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (k = 0; k <= 24; k += 4) begin
            apb(1'b0, 8'(k), 32'h0);
            check(rd, 32'h0);
        end
        $display("test of reset values done");
        for (k = 0; k < 5; k++) run(k, 8);
        run(1, 260);
        tally_and_finish();
    end
endmodule : tb_adc_result_computation_unit
`default_nettype wire
